// ### slpr_defs.svh
/*
   Constants of the connectionless ARP/echo engine: register offsets, field
   positions, reset values and the retry tick. Included by bare name; holds
   definitions only.
*/
`ifndef SLPR_DEFS_SVH
`define SLPR_DEFS_SVH

// Retry tick: 100 us at a 25 MHz core clock
`define SLPR_TICK_US        100
`define SLPR_CLK_MHZ        25
`define SLPR_TICK_CYC       (`SLPR_TICK_US * `SLPR_CLK_MHZ)
`define SLPR_TICK_W         12

// Wishbone byte offsets (low address byte)
`define SLPR_A_CMD          8'h00
`define SLPR_A_FLAGS        8'h04
`define SLPR_A_MASK         8'h08
`define SLPR_A_RTR          8'h0c
`define SLPR_A_RCR          8'h10
`define SLPR_A_PIP          8'h14
`define SLPR_A_SEQ          8'h18
`define SLPR_A_ID           8'h1c
`define SLPR_A_PHA_LO       8'h20
`define SLPR_A_PHA_HI       8'h24
`define SLPR_A_CH_RTR       8'h28
`define SLPR_A_CH_RCR       8'h2c
`define SLPR_A_CH_CMD       8'h30
`define SLPR_A_CH_FLAGS     8'h34
`define SLPR_A_CH_IP        8'h38
`define SLPR_A_PEND         8'h3c

// Command and flag bit positions
`define SLPR_CMD_ARP        0
`define SLPR_CMD_PING       1
`define SLPR_FL_TIMEOUT     0
`define SLPR_FL_PING        1
`define SLPR_FL_ARP         2
`define SLPR_CH_CONNECT     0
`define SLPR_CH_SEND        1
`define SLPR_CH_DISCONNECT_CMD      2
`define SLPR_CHF_ACKED      0
`define SLPR_CHF_TIMEOUT    1

// Reset values
`define SLPR_RTR_RST        16'h07d0
`define SLPR_RCR_RST        8'h08
`define SLPR_BYTE_ZERO      8'h00

`endif

// ### slpr_pkg.sv
/*
   Types of the connectionless ARP/echo engine: packet kinds, engine states
   and the request and reply carriers. Assumes nothing of its surroundings.
*/
`default_nettype none
package slpr_pkg;

   typedef enum logic [2:0]
   {
      KIND_ARP  = 3'h0,
      KIND_ECHO = 3'h1,
      KIND_SYN  = 3'h2,
      KIND_DATA = 3'h3,
      KIND_FIN  = 3'h4,
      KIND_ACK  = 3'h5
   } slpr_kind_e;

   typedef enum logic [1:0]
   {
      SL_IDLE = 2'b01,
      SL_WAIT = 2'b10
   } slpr_sl_state_e;

   typedef enum logic [2:0]
   {
      CH_IDLE = 3'b001,
      CH_ARP  = 3'b010,
      CH_SEG  = 3'b100
   } slpr_ch_state_e;

   typedef struct packed
   {
      slpr_kind_e  kind;
      logic [31:0] dst_ip;
      logic [15:0] echo_id;
      logic [15:0] echo_seq;
   } slpr_tx_s;

   typedef struct packed
   {
      slpr_kind_e  kind;
      logic [31:0] src_ip;
      logic [47:0] src_hw;
      logic [15:0] echo_id;
      logic [15:0] echo_seq;
   } slpr_rx_s;

endpackage
`default_nettype wire

// ### slpr_retry_timer.sv
/*
   Retransmission interval timer. Counts 100 us ticks and pulses on expiry,
   reloading itself; in backoff mode the interval doubles after each expiry
   until doubling again would pass 16 bits. Assumes the tick is a one-cycle
   enable from the same clock.
*/
`default_nettype none
`include "slpr_defs.svh"
module slpr_retry_timer
(
   input  wire logic        core_clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        tick_in,
   input  wire logic        start_in,
   input  wire logic        stop_in,
   input  wire logic        backoff_in,
   input  wire logic [15:0] interval_in,
   output logic             expire_out
);
   logic        run;
   logic        backoff;
   logic [15:0] cur;
   logic [15:0] remain;
   logic [15:0] next_cur;

   // A doubling that would pass 65535 is skipped; the interval stays capped
   always_comb
   begin
      next_cur = cur;
      if (backoff && !cur[15])
      begin
         next_cur = {cur[14:0], 1'b0};
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         run        <= 1'b0;
         backoff    <= 1'b0;
         cur        <= 16'h0001;
         remain     <= 16'h0001;
         expire_out <= 1'b0;
      end
      else
      begin
         expire_out <= 1'b0;
         if (start_in)
         begin
            // A zero interval would wrap and expire only after 65536 ticks; treat it as one tick
            run     <= 1'b1;
            backoff <= backoff_in;
            cur     <= (interval_in == 16'h0000) ? 16'h0001 : interval_in;
            remain  <= (interval_in == 16'h0000) ? 16'h0001 : interval_in;
         end
         else if (stop_in)
         begin
            run <= 1'b0;
         end
         else if (run && tick_in)
         begin
            if (remain == 16'h0001)
            begin
               expire_out <= 1'b1;
               cur        <= next_cur;
               remain     <= next_cur;
            end
            else
            begin
               remain <= remain - 16'h0001;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### slpr_engine.sv
/*
   Connectionless ARP and echo request engine with one TCP channel's
   retransmission control, reached over a classic Wishbone slave.
   Assumes a packet layer on the same clock: it takes every tx pulse and
   delivers each parsed reply as a one-cycle rx pulse.
*/
`default_nettype none
`include "slpr_defs.svh"
// How it works
// - Setting the ARP or ping command bit sends that request, no channel needed.
// - A matching reply sets the ARP-reply or ping-reply flag.
// - An ARP reply stores the answering peer's hardware address.
// - An echo reply also stores the peer's hardware address.
// - Command register returns to zero once accepted; host polls for zero.
// - Without a reply the request is resent each interval until answered.
// - When resends exceed the retry count, resending stops and timeout is flagged.
// - Request timeout is interval times 0.1 ms times retry count plus one.
// - Retry interval is 16 bits, low byte in byte lane 0, in 100 us units.
// - ARP timeouts go to the connectionless flag or the channel flag.
// - Ping timeouts come only from the ping command, to the connectionless flag.
// - Unacknowledged SYN, FIN or data segments are resent until acknowledged.
// - TCP interval doubles per retry until doubling would pass 65535.
// - TCP timeout from connect, send or disconnect sets the channel timeout flag.
// - Separate mask bits exist for ARP-reply, ping-reply and timeout events.
module slpr_engine
(
   input  wire logic             core_clk_in,
   input  wire logic             arst_n_in,
   input  wire logic             wb_cyc_in,
   input  wire logic             wb_stb_in,
   input  wire logic             wb_we_in,
   input  wire logic [7:0]       wb_adr_in,
   input  wire logic [3:0]       wb_sel_in,
   input  wire logic [31:0]      wb_dat_in,
   output logic      [31:0]      wb_dat_out,
   output logic                  wb_ack_out,
   output logic                  tx_valid_out,
   output slpr_pkg::slpr_tx_s    tx_req_out,
   input  wire logic             rx_valid_in,
   input  wire slpr_pkg::slpr_rx_s rx_reply_in
);
   // Byte-lane merge, used by every writable register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   logic [`SLPR_TICK_W-1:0] tick_cnt;
   logic                    tick;
   logic                    wr;
   logic                    rd_req;
   logic [31:0]             wmask;
   logic [1:0]              command;
   logic [2:0]              flags;
   logic [2:0]              mask;
   logic [15:0]             rtr;
   logic [7:0]              rcr;
   logic [31:0]             peer_ip_address;
   logic [15:0]             echo_sequence_number;
   logic [15:0]             echo_identifier;
   logic [47:0]             peer_hw_address;
   logic [15:0]             ch_rtr;
   logic [7:0]              ch_rcr;
   logic [2:0]              ch_cmd;
   logic [1:0]              ch_flags;
   logic [31:0]             ch_ip;
   logic [31:0]             rdata;
   slpr_pkg::slpr_sl_state_e sl_state;
   slpr_pkg::slpr_ch_state_e ch_state;
   slpr_pkg::slpr_kind_e    sl_kind;
   slpr_pkg::slpr_kind_e    ch_kind;
   logic [7:0]              sl_tries;
   logic [7:0]              ch_tries;
   logic                    ch_resolved;
   logic                    ch_pend;
   logic                    sl_accept;
   logic                    sl_match;
   logic                    sl_send;
   logic                    sl_stop;
   logic                    sl_expire;
   logic                    ch_accept;
   logic                    ch_arp_ok;
   logic                    ch_ack;
   logic                    ch_send;
   logic                    ch_start;
   logic                    ch_backoff;
   logic                    ch_stop;
   logic                    ch_expire;
   logic [2:0]              flag_set;
   logic [1:0]              ch_flag_set;

   // 100 us retry tick
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         tick_cnt <= '0;
      end
      else if (tick)
      begin
         tick_cnt <= '0;
      end
      else
      begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end
   assign tick = (tick_cnt == `SLPR_TICK_W'(`SLPR_TICK_CYC - 1));

   // Wishbone: ack one cycle after the request; writes land on the ack edge
   assign rd_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign wr     = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;
   assign wmask  = merge(32'h0000_0000, wb_dat_in, wb_sel_in);

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= '0;
      end
      else
      begin
         wb_ack_out <= rd_req;
         if (rd_req)
         begin
            wb_dat_out <= rdata;
         end
      end
   end

   always_comb
   begin
      rdata = '0;
      unique case (wb_adr_in)
         `SLPR_A_CMD:      rdata = {30'h0, command};
         `SLPR_A_FLAGS:    rdata = {29'h0, flags};
         `SLPR_A_MASK:     rdata = {29'h0, mask};
         `SLPR_A_RTR:      rdata = {16'h0, rtr};
         `SLPR_A_RCR:      rdata = {24'h0, rcr};
         `SLPR_A_PIP:      rdata = peer_ip_address;
         `SLPR_A_SEQ:      rdata = {16'h0, echo_sequence_number};
         `SLPR_A_ID:       rdata = {16'h0, echo_identifier};
         `SLPR_A_PHA_LO:   rdata = peer_hw_address[31:0];
         `SLPR_A_PHA_HI:   rdata = {16'h0, peer_hw_address[47:32]};
         `SLPR_A_CH_RTR:   rdata = {16'h0, ch_rtr};
         `SLPR_A_CH_RCR:   rdata = {24'h0, ch_rcr};
         `SLPR_A_CH_CMD:   rdata = {29'h0, ch_cmd};
         `SLPR_A_CH_FLAGS: rdata = {30'h0, ch_flags};
         `SLPR_A_CH_IP:    rdata = ch_ip;
         `SLPR_A_PEND:     rdata = {29'h0, flags & mask};
         default:          rdata = '0;
      endcase
   end

   // Plain configuration registers
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         mask                 <= '0;
         rtr                  <= `SLPR_RTR_RST;
         rcr                  <= `SLPR_RCR_RST;
         peer_ip_address      <= '0;
         echo_sequence_number <= '0;
         echo_identifier      <= '0;
         ch_rtr               <= `SLPR_RTR_RST;
         ch_rcr               <= `SLPR_RCR_RST;
         ch_ip                <= '0;
      end
      else if (wr)
      begin
         unique case (wb_adr_in)
            `SLPR_A_MASK:   mask <= 3'(merge({29'h0, mask}, wb_dat_in, wb_sel_in));
            `SLPR_A_RTR:    rtr <= 16'(merge({16'h0, rtr}, wb_dat_in, wb_sel_in));
            `SLPR_A_RCR:    rcr <= 8'(merge({24'h0, rcr}, wb_dat_in, wb_sel_in));
            `SLPR_A_PIP:    peer_ip_address <= merge(peer_ip_address, wb_dat_in, wb_sel_in);
            `SLPR_A_SEQ:
               echo_sequence_number <= 16'(merge({16'h0, echo_sequence_number}, wb_dat_in,
                                                 wb_sel_in));
            `SLPR_A_ID:
               echo_identifier <= 16'(merge({16'h0, echo_identifier}, wb_dat_in, wb_sel_in));
            `SLPR_A_CH_RTR: ch_rtr <= 16'(merge({16'h0, ch_rtr}, wb_dat_in, wb_sel_in));
            `SLPR_A_CH_RCR: ch_rcr <= 8'(merge({24'h0, ch_rcr}, wb_dat_in, wb_sel_in));
            `SLPR_A_CH_IP:  ch_ip <= merge(ch_ip, wb_dat_in, wb_sel_in);
            default:        ;
         endcase
      end
   end

   // Command registers: software sets, the engine clears on acceptance
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         command <= '0;
         ch_cmd  <= '0;
      end
      else
      begin
         if (wr && wb_adr_in == `SLPR_A_CMD)
         begin
            command <= 2'(merge({30'h0, command}, wb_dat_in, wb_sel_in));
         end
         else if (sl_accept)
         begin
            command <= '0;
         end
         if (wr && wb_adr_in == `SLPR_A_CH_CMD)
         begin
            ch_cmd <= 3'(merge({29'h0, ch_cmd}, wb_dat_in, wb_sel_in));
         end
         else if (ch_accept)
         begin
            ch_cmd <= '0;
         end
      end
   end

   // Sticky flags: hardware set wins over a write-one clear
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         flags    <= '0;
         ch_flags <= '0;
      end
      else
      begin
         flags <= (flags & ~((wr && wb_adr_in == `SLPR_A_FLAGS) ? wmask[2:0] : 3'h0))
                  | flag_set;
         ch_flags <= (ch_flags & ~((wr && wb_adr_in == `SLPR_A_CH_FLAGS) ? wmask[1:0] : 2'h0))
                     | ch_flag_set;
      end
   end

   // Connectionless engine
   assign sl_accept = (sl_state == slpr_pkg::SL_IDLE) && (command != 2'h0);
   assign sl_match  = (sl_state == slpr_pkg::SL_WAIT) && rx_valid_in
                      && (rx_reply_in.src_ip == peer_ip_address)
                      && (((sl_kind == slpr_pkg::KIND_ARP)
                           && (rx_reply_in.kind == slpr_pkg::KIND_ARP))
                          || ((sl_kind == slpr_pkg::KIND_ECHO)
                              && (rx_reply_in.kind == slpr_pkg::KIND_ECHO)
                              && (rx_reply_in.echo_id == echo_identifier)
                              && (rx_reply_in.echo_seq == echo_sequence_number)));
   assign sl_send = sl_accept || ((sl_state == slpr_pkg::SL_WAIT) && !sl_match
                                  && sl_expire && (sl_tries != rcr));
   assign sl_stop = sl_match || ((sl_state == slpr_pkg::SL_WAIT) && sl_expire
                                 && (sl_tries == rcr));

   always_comb
   begin
      flag_set = '0;
      if (sl_match)
      begin
         flag_set[`SLPR_FL_ARP]  = (sl_kind == slpr_pkg::KIND_ARP);
         flag_set[`SLPR_FL_PING] = (sl_kind == slpr_pkg::KIND_ECHO);
      end
      else if (sl_stop)
      begin
         flag_set[`SLPR_FL_TIMEOUT] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         sl_state        <= slpr_pkg::SL_IDLE;
         sl_kind         <= slpr_pkg::KIND_ARP;
         sl_tries        <= '0;
         peer_hw_address <= '0;
      end
      else
      begin
         unique case (sl_state)
            slpr_pkg::SL_IDLE:
               if (sl_accept)
               begin
                  sl_state <= slpr_pkg::SL_WAIT;
                  sl_tries <= '0;
                  sl_kind  <= command[`SLPR_CMD_ARP] ? slpr_pkg::KIND_ARP : slpr_pkg::KIND_ECHO;
               end
            slpr_pkg::SL_WAIT:
            begin
               if (sl_match)
               begin
                  peer_hw_address <= rx_reply_in.src_hw;
               end
               if (sl_stop)
               begin
                  sl_state <= slpr_pkg::SL_IDLE;
               end
               else if (sl_send)
               begin
                  sl_tries <= sl_tries + 8'h01;
               end
            end
         endcase
      end
   end

   // Channel engine: address resolution, then segment with backoff
   assign ch_accept = (ch_state == slpr_pkg::CH_IDLE) && (ch_cmd != 3'h0);
   assign ch_arp_ok = (ch_state == slpr_pkg::CH_ARP) && rx_valid_in
                      && (rx_reply_in.kind == slpr_pkg::KIND_ARP) && (rx_reply_in.src_ip == ch_ip);
   assign ch_ack    = (ch_state == slpr_pkg::CH_SEG) && rx_valid_in
                      && (rx_reply_in.kind == slpr_pkg::KIND_ACK) && (rx_reply_in.src_ip == ch_ip);
   assign ch_stop   = ch_ack || ((ch_state != slpr_pkg::CH_IDLE) && !ch_arp_ok && ch_expire
                                 && (ch_tries == ch_rcr));
   assign ch_start  = (ch_accept) || ch_arp_ok;
   assign ch_backoff = ch_arp_ok || (ch_accept && ch_resolved);
   assign ch_send   = ch_start || ((ch_state != slpr_pkg::CH_IDLE) && !ch_ack && !ch_arp_ok
                                   && ch_expire && (ch_tries != ch_rcr));

   always_comb
   begin
      ch_flag_set = '0;
      ch_flag_set[`SLPR_CHF_ACKED] = ch_ack;
      ch_flag_set[`SLPR_CHF_TIMEOUT] = ch_stop && !ch_ack;
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ch_state    <= slpr_pkg::CH_IDLE;
         ch_kind     <= slpr_pkg::KIND_SYN;
         ch_tries    <= '0;
         ch_resolved <= 1'b0;
      end
      else
      begin
         if (ch_start)
         begin
            ch_tries <= '0;
         end
         else if (ch_send)
         begin
            ch_tries <= ch_tries + 8'h01;
         end
         unique case (ch_state)
            slpr_pkg::CH_IDLE:
               if (ch_accept)
               begin
                  ch_state <= ch_resolved ? slpr_pkg::CH_SEG : slpr_pkg::CH_ARP;
                  ch_kind  <= ch_cmd[`SLPR_CH_CONNECT] ? slpr_pkg::KIND_SYN :
                              ch_cmd[`SLPR_CH_SEND]    ? slpr_pkg::KIND_DATA : slpr_pkg::KIND_FIN;
               end
            slpr_pkg::CH_ARP:
               if (ch_arp_ok)
               begin
                  ch_resolved <= 1'b1;
                  ch_state    <= slpr_pkg::CH_SEG;
               end
               else if (ch_stop)
               begin
                  ch_state <= slpr_pkg::CH_IDLE;
               end
            slpr_pkg::CH_SEG:
               if (ch_stop)
               begin
                  ch_state <= slpr_pkg::CH_IDLE;
                  // A closed connection must resolve the peer again next time
                  if (ch_kind == slpr_pkg::KIND_FIN)
                  begin
                     ch_resolved <= 1'b0;
                  end
               end
         endcase
      end
   end

   slpr_retry_timer u_sl_timer
   (
      .core_clk_in (core_clk_in),
      .arst_n_in   (arst_n_in),
      .tick_in     (tick),
      .start_in    (sl_accept),
      .stop_in     (sl_stop),
      .backoff_in  (1'b0),
      .interval_in (rtr),
      .expire_out  (sl_expire)
   );

   slpr_retry_timer u_ch_timer
   (
      .core_clk_in (core_clk_in),
      .arst_n_in   (arst_n_in),
      .tick_in     (tick),
      .start_in    (ch_start),
      .stop_in     (ch_stop),
      .backoff_in  (ch_backoff),
      .interval_in (ch_rtr),
      .expire_out  (ch_expire)
   );

   // Transmit: connectionless first; a channel request waits one slot at most
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         tx_valid_out <= 1'b0;
         tx_req_out   <= '0;
         ch_pend      <= 1'b0;
      end
      else
      begin
         tx_valid_out <= sl_send || ch_send || ch_pend;
         ch_pend      <= (ch_send || ch_pend) && sl_send;
         if (sl_send)
         begin
            tx_req_out.kind     <= !sl_accept ? sl_kind : command[`SLPR_CMD_ARP] ?
                                   slpr_pkg::KIND_ARP : slpr_pkg::KIND_ECHO;
            tx_req_out.dst_ip   <= peer_ip_address;
            tx_req_out.echo_id  <= echo_identifier;
            tx_req_out.echo_seq <= echo_sequence_number;
         end
         else if (ch_send || ch_pend)
         begin
            tx_req_out.kind     <= (ch_state == slpr_pkg::CH_IDLE && !ch_resolved)
                                   || (ch_state == slpr_pkg::CH_ARP && !ch_arp_ok) ?
                                   slpr_pkg::KIND_ARP :
                                   (ch_state == slpr_pkg::CH_IDLE ?
                                    (ch_cmd[`SLPR_CH_CONNECT] ? slpr_pkg::KIND_SYN :
                                     ch_cmd[`SLPR_CH_SEND] ? slpr_pkg::KIND_DATA :
                                     slpr_pkg::KIND_FIN)
                                    : ch_kind);
            tx_req_out.dst_ip   <= ch_ip;
            tx_req_out.echo_id  <= '0;
            tx_req_out.echo_seq <= '0;
         end
      end
   end
endmodule
`default_nettype wire

// ### slpr_engine_asserts.sv
/* Checker for slpr_engine: bus handshake, request launch, read widths.
   Sees only the engine ports; bound below. */
`default_nettype none
module slpr_engine_chk
(
   input wire logic               core_clk_in,
   input wire logic               arst_n_in,
   input wire logic               wb_cyc_in,
   input wire logic               wb_stb_in,
   input wire logic               wb_we_in,
   input wire logic [7:0]         wb_adr_in,
   input wire logic [3:0]         wb_sel_in,
   input wire logic [31:0]        wb_dat_out,
   input wire logic [31:0]        wb_dat_in,
   input wire logic               wb_ack_out,
   input wire logic               tx_valid_out,
   input wire slpr_pkg::slpr_tx_s tx_req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   wire logic rd = wb_ack_out && !wb_we_in;
   wire logic cw = wb_ack_out && wb_we_in && wb_adr_in == 8'h00 && wb_sel_in[0];
   a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
   a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("no ack");
   a_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
      else $error("stray ack");
   a_arp_launch: assert property (
      cw && wb_dat_in[0] |-> ##[1:3] tx_valid_out && tx_req_out.kind == slpr_pkg::KIND_ARP)
      else $error("no arp request");
   a_ping_launch: assert property (
      cw && wb_dat_in[1:0] == 2'h2 |-> ##[1:3] tx_valid_out
      && tx_req_out.kind == slpr_pkg::KIND_ECHO)
      else $error("no echo request");
   a_interval_width: assert property (
      rd && wb_adr_in == 8'h0c |-> wb_dat_out[31:16] == 16'h0000) else $error("interval wide");
   a_flag_width: assert property (
      rd && wb_adr_in == 8'h04 |-> wb_dat_out[31:3] == 29'h0) else $error("flags wide");
   a_unmapped_zero: assert property (
      rd && wb_adr_in[7:6] != 2'h0 |-> wb_dat_out == 32'h0) else $error("unmapped read");
endmodule
bind slpr_engine slpr_engine_chk chk (.*);
`default_nettype wire

// ### slpr_peer_model.sv
/* Remote peer: answers ARP and echo requests after a delay, or stays silent.
   Assumes the engine's packet carriers on one clock. */
`default_nettype none
module slpr_peer_model
(
   input  wire logic               clk_in,
   input  wire logic               arst_n_in,
   input  wire logic               tx_valid_in,
   input  wire slpr_pkg::slpr_tx_s tx_req_in,
   input  wire logic               answer_in,
   input  wire logic [3:0]         delay_in,
   input  wire logic [47:0]        hw_in,
   output logic                    rx_valid_out,
   output slpr_pkg::slpr_rx_s      rx_reply_out,
   output logic [7:0]              sent_out
);
   timeunit 1ns;
   timeprecision 1ps;
   slpr_pkg::slpr_tx_s req;
   logic [3:0]         cnt;
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in)
      begin
         cnt <= 4'h0;
         sent_out <= 8'h00;
         rx_valid_out <= 1'b0;
         rx_reply_out <= '0;
      end
      else
      begin
         rx_valid_out <= cnt == 4'h1;
         // Idle carrier toggles so a stale reply is never mistaken for a fresh one
         rx_reply_out <= (cnt == 4'h1) ?
            {(req.kind > slpr_pkg::KIND_ECHO) ? slpr_pkg::KIND_ACK : req.kind, req.dst_ip,
             hw_in, req.echo_id, req.echo_seq} : ~rx_reply_out;
         cnt <= (cnt != 4'h0) ? cnt - 4'h1 : cnt;
         if (tx_valid_in)
         begin
            sent_out <= sent_out + 8'h01;
            cnt <= answer_in ? delay_in : 4'h0;
            req <= tx_req_in;
         end
      end
endmodule
`default_nettype wire

// ### tb_top.sv
/* Testbench for slpr_engine: Wishbone tasks, peer model, reply and timeout
   runs. Assumes a single 25 MHz clock. */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clk, rst_n, cyc, stb, we, ack, txv, rxv, ans;
   logic [7:0]         adr, sent, n0;
   logic [3:0]         sel, dly;
   logic [31:0]        dat, rdat, q, exp;
   logic [47:0]        hw;
   slpr_pkg::slpr_tx_s txr;
   slpr_pkg::slpr_rx_s rxr;
   int                 err_count, checks;
   slpr_engine uut (.core_clk_in(clk), .arst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .tx_valid_out(txv), .tx_req_out(txr), .rx_valid_in(rxv),
      .rx_reply_in(rxr));
   slpr_peer_model peer (.clk_in(clk), .arst_n_in(rst_n), .tx_valid_in(txv), .tx_req_in(txr),
      .answer_in(ans), .delay_in(dly), .hw_in(hw), .rx_valid_out(rxv), .rx_reply_out(rxr),
      .sent_out(sent));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Bounded poll; a stuck field surfaces as a mismatch on the last read
   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      int i;
      i = 0;
      do begin wb(1'b0, a, 32'h0); i++; end while ((q & m) !== e && i < 5000);
      chk(q & m, e);
   endtask
   task end_sim;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hf;
      dat = 32'h0; ans = 1'b0; dly = 4'h1; hw = 48'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      wb(1'b0, 8'h0c, 32'h0); chk(q, 32'h7d0);
      wb(1'b0, 8'h10, 32'h0); chk(q, 32'h8);
      wb(1'b0, 8'h40, 32'h0); chk(q, 32'h0);
      wb(1'b1, 8'h08, 32'h7); wb(1'b0, 8'h08, 32'h0); chk(q, 32'h7);
      wb(1'b1, 8'h0c, 32'h1); wb(1'b1, 8'h10, 32'h1);
      wb(1'b1, 8'h14, 32'hc0a80064);
      wb(1'b1, 8'h18, 32'h3e8); wb(1'b1, 8'h1c, 32'h100);
      for (int a = 0; a < 2; a++)
         for (int c = 1; c < 3; c++)
         begin
            ans <= a == 0; dly <= 4'(c * 3); hw <= 48'h02aabbccdd00 + 48'(c); n0 = sent;
            exp = a ? 32'h1 : 32'(6 - 2 * c);
            wb(1'b1, 8'h00, 32'(c));
            poll(8'h00, 32'hff, 32'h0);
            poll(8'h04, 32'h7, exp);
            wb(1'b0, 8'h20, 32'h0);
            if (a == 0) chk(q, hw[31:0]);
            else chk(32'(sent - n0), 32'h2);
            wb(1'b0, 8'h24, 32'h0);
            if (a == 0) chk(q, {16'h0, hw[47:32]});
            wb(1'b1, 8'h04, 32'h0); wb(1'b0, 8'h04, 32'h0); chk(q, exp);
            wb(1'b1, 8'h04, exp); wb(1'b0, 8'h04, 32'h0); chk(q, 32'h0);
         end
      // Two ticks keep the answered run free of an early resend
      wb(1'b1, 8'h2c, 32'h1); wb(1'b1, 8'h38, 32'hc0a80064);
      for (int a = 0; a < 2; a++)
      begin
         ans <= a == 0; n0 = sent;
         wb(1'b1, 8'h28, 32'(2 - a)); wb(1'b1, 8'h30, 32'h1);
         poll(8'h34, 32'h3, 32'(a + 1));
         chk(32'(sent - n0), 32'h2);
         wb(1'b1, 8'h34, 32'h3);
      end
      end_sim;
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      err_count++;
      end_sim;
   end
endmodule
`default_nettype wire
